/* asm_cfg.svh */
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH
`define ASM_ADDR_W 23
`define ASM_A20_POS 19
`define ASM_BYTE_SEL_BOTH 2'h0
`endif

/* asm_pkg.sv */
package asm_pkg;
    // Bus request from the core side of the bus unit
    typedef struct packed {
        logic [22:0] phys_addr_lines;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
        logic [2:0] cycle_def;
    } asm_req_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_WAIT = 3'h4
    } asm_state_e;
endpackage

/* asm_sync2.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a pin input
module asm_sync2 (
    input wire logic mclk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    logic s1_ff;
    logic s2_ff;
    logic nxt_s1;
    logic nxt_s2;
    // Reset to high: pin pulled up reads inactive
    always_comb begin
        nxt_s1 = srst ? 1'h1 : din;
        nxt_s2 = srst ? 1'h1 : s1_ff;
    end
    always_ff @(posedge mclk) begin
        s1_ff <= nxt_s1;
        s2_ff <= nxt_s2;
    end
    assign dout = s2_ff;
endmodule

/* asm_bus_strobe.sv */
`timescale 1ns/1ps
`include "asm_cfg.svh"
module asm_bus_strobe (
    input wire logic mclk,
    input wire logic srst,
    input wire asm_pkg::asm_req_s req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic pipeline_en,
    input wire logic ready_n,
    input wire logic float_req,
    input wire logic paging_en,
    input wire logic bit20_mask_enable,
    input wire logic bit20_mask_in_n,
    output logic [22:0] cache_addr,
    output asm_pkg::asm_req_s bus_out,
    output logic bus_out_oe,
    output logic cycle_addr_strobe_n,
    output logic cycle_addr_strobe_oe
);
    import asm_pkg::*;

    logic mask_pin_n;
    asm_state_e state_ff;
    asm_state_e nxt_state;
    logic busy_ff;
    logic nxt_busy;
    logic strobe_ff;
    logic nxt_strobe;
    logic mask_en_ff;
    logic nxt_mask_en;
    asm_req_s out_ff;
    asm_req_s nxt_out;
    asm_req_s fixed;
    logic mask_act;
    logic ready_s;
    logic float_s;

    // Pin inputs cross into mclk domain first
    asm_sync2 u_sync_mask (
        .mclk(mclk),
        .srst(srst),
        .din(bit20_mask_in_n),
        .dout(mask_pin_n)
    );
    asm_sync2 u_sync_rdy (
        .mclk(mclk),
        .srst(srst),
        .din(ready_n),
        .dout(ready_s)
    );
    asm_sync2 u_sync_flt (
        .mclk(mclk),
        .srst(srst),
        .din(~float_req),
        .dout(float_s)
    );

    // Masking needs the enable bit, the pin low and paging off
    assign mask_act = mask_en_ff && !mask_pin_n && !paging_en;
    always_comb begin
        fixed = req;
        if (mask_act) begin
            fixed.phys_addr_lines[`ASM_A20_POS] = 1'h0;
        end
        // Forbidden all-idle lanes become a full word access
        if (req.upper_byte_sel_n && req.lower_byte_sel_n) begin
            {fixed.upper_byte_sel_n, fixed.lower_byte_sel_n} = `ASM_BYTE_SEL_BOTH;
        end
    end
    assign cache_addr = fixed.phys_addr_lines;

    // Next cycle may start when idle, or pipelined while previous is pending
    // Ready is seen through the synchroniser, so it ends a cycle two clocks late
    assign req_ready = float_s && !strobe_ff && (!busy_ff || pipeline_en || !ready_s);

    // Cycle sequencer: address latched on the same edge that raises the strobe
    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_strobe = 1'h0;
        nxt_out = out_ff;
        nxt_mask_en = bit20_mask_enable;
        if (busy_ff && !ready_s) begin
            nxt_busy = 1'h0;
        end
        case (state_ff)
            ST_IDLE, ST_WAIT: begin
                if (req_valid && req_ready) begin
                    nxt_out = fixed;
                    nxt_strobe = 1'h1;
                    nxt_state = ST_ADDR;
                end else if (!nxt_busy) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ADDR: begin
                // Pipelined strobe stays until the earlier cycle completes
                if (busy_ff && ready_s) begin
                    nxt_strobe = 1'h1;
                end else begin
                    nxt_busy = 1'h1;
                    nxt_state = ST_WAIT;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Reset parks the pins at a legal idle pattern: one lane, no strobe
        if (srst) begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'h0;
            nxt_strobe = 1'h0;
            nxt_mask_en = 1'h0;
            nxt_out = '0;
            nxt_out.upper_byte_sel_n = 1'h1;
        end
    end
    // Registers only; every decision is made in the process above
    always_ff @(posedge mclk) begin
        state_ff <= nxt_state;
        busy_ff <= nxt_busy;
        strobe_ff <= nxt_strobe;
        mask_en_ff <= nxt_mask_en;
        out_ff <= nxt_out;
    end

    // Pin drivers; enables follow the synchronised float request
    assign bus_out = out_ff;
    assign cycle_addr_strobe_n = !strobe_ff;
    assign cycle_addr_strobe_oe = float_s;
    assign bus_out_oe = float_s;

    // Steps of a strobe: start, held behind a pending cycle, released by ready
    // Checks use the synchronised pins, exactly as the sequencer sees them, except a_float_strobe and a_float_drive, which use the raw float_req pin
    sequence s_strobe_start;
        $rose(strobe_ff);
    endsequence
    sequence s_prev_pending;
        strobe_ff && busy_ff && ready_s;
    endsequence
    sequence s_prev_done;
        strobe_ff && busy_ff && !ready_s;
    endsequence

    // Strobe timing and the address it qualifies
    a_strobe_single: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_start ##0 !busy_ff |=> !strobe_ff)
        else $error("strobe held past first clock");
    a_strobe_pipe: assert property (@(posedge mclk) disable iff (srst)
        s_prev_pending |=> strobe_ff)
        else $error("pipelined strobe dropped early");
    a_strobe_release: assert property (@(posedge mclk) disable iff (srst)
        s_prev_done |=> !strobe_ff && busy_ff)
        else $error("pipelined strobe kept after ready");
    a_nopipe_refuse: assert property (@(posedge mclk) disable iff (srst)
        !pipeline_en && busy_ff && ready_s |-> !req_ready)
        else $error("new cycle taken while one is pending");
    a_take_strobe: assert property (@(posedge mclk) disable iff (srst)
        req_valid && req_ready |=> $rose(strobe_ff) && bus_out == $past(fixed))
        else $error("taken request gave no strobe");
    a_addr_stable: assert property (@(posedge mclk) disable iff (srst)
        strobe_ff && $past(strobe_ff) |-> $stable(bus_out))
        else $error("address moved under the strobe");
    a_valid_addr: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_start |-> out_ff == $past(fixed))
        else $error("strobe without latched address");

    // Float: the pin drives the enables after the synchroniser delay
    a_float_strobe: assert property (@(posedge mclk) disable iff (srst)
        float_req [*3] |-> !cycle_addr_strobe_oe && !bus_out_oe)
        else $error("strobe driven while floating");
    a_float_drive: assert property (@(posedge mclk) disable iff (srst)
        !float_req [*3] |-> cycle_addr_strobe_oe && bus_out_oe)
        else $error("pins still floating after release");
    a_float_no_cycle: assert property (@(posedge mclk) disable iff (srst)
        !float_s |=> !$rose(strobe_ff))
        else $error("cycle started while floating");

    // Byte lanes
    a_byte_lane: assert property (@(posedge mclk) disable iff (srst)
        strobe_ff |-> !(out_ff.upper_byte_sel_n && out_ff.lower_byte_sel_n))
        else $error("no byte lane selected");
    a_lane_cycle: assert property (@(posedge mclk) disable iff (srst)
        busy_ff |-> !(out_ff.upper_byte_sel_n && out_ff.lower_byte_sel_n))
        else $error("no byte lane selected in cycle");

    // Address bit 20 masking, on the cache side and on the bus
    a_page_nomask: assert property (@(posedge mclk) disable iff (srst)
        paging_en |-> cache_addr[`ASM_A20_POS] == req.phys_addr_lines[`ASM_A20_POS])
        else $error("bit 20 masked with paging");
    a_mask_force: assert property (@(posedge mclk) disable iff (srst)
        mask_en_ff && !mask_pin_n && !paging_en |-> !cache_addr[`ASM_A20_POS])
        else $error("bit 20 not forced low");
    a_mask_ignored: assert property (@(posedge mclk) disable iff (srst)
        !mask_en_ff |-> cache_addr == req.phys_addr_lines)
        else $error("mask applied while disabled");
    a_mask_bus: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_start ##0 $past(mask_en_ff && !mask_pin_n && !paging_en) |->
        !bus_out.phys_addr_lines[`ASM_A20_POS])
        else $error("bus bit 20 not forced low");
    a_page_bus: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_start ##0 $past(paging_en) |->
        bus_out.phys_addr_lines[`ASM_A20_POS] == $past(req.phys_addr_lines[`ASM_A20_POS]))
        else $error("bus bit 20 masked with paging");

    // Reset leaves masking off and no strobe out
    a_reset_idle: assert property (@(posedge mclk)
        srst |=> !mask_en_ff && cycle_addr_strobe_n)
        else $error("enable or strobe active after reset");
endmodule

/* asm_sys_model.sv */
`timescale 1ns/1ps
// System logic: ready, hold and mask pins
module asm_sys_model (
    input wire logic mclk,
    input wire logic rdy_go,
    input wire logic hold_go,
    input wire logic mask_go,
    output logic ready_n,
    output logic float_req,
    output logic bit20_mask_in_n
);
    // Ready answers one clock after the request to end a cycle
    always_ff @(posedge mclk) begin
        ready_n <= !rdy_go;
    end
    assign float_req = hold_go;
    // Undriven mask pin sits at the pull-up level
    assign bit20_mask_in_n = mask_go ? 1'h0 : 1'h1;
endmodule

/* tb_asm_bus_strobe.sv */
`timescale 1ns/1ps
module tb_asm_bus_strobe;
    import asm_pkg::*;
    logic mclk = 0, srst = 1, req_valid = 0, pipeline_en = 0, paging_en = 0;
    logic bit20_mask_enable = 0, rdy_go = 0, hold_go = 0, mask_go = 0;
    logic req_ready, ready_n, float_req, bit20_mask_in_n, bus_out_oe;
    logic cycle_addr_strobe_n, cycle_addr_strobe_oe;
    logic [22:0] cache_addr;
    asm_req_s req = '0, bus_out;
    int mismatches = 0, checked = 0;
    asm_bus_strobe i_asm_bus_strobe (.mclk(mclk), .srst(srst), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .pipeline_en(pipeline_en),
        .ready_n(ready_n), .float_req(float_req), .paging_en(paging_en),
        .bit20_mask_enable(bit20_mask_enable), .bit20_mask_in_n(bit20_mask_in_n),
        .cache_addr(cache_addr), .bus_out(bus_out), .bus_out_oe(bus_out_oe),
        .cycle_addr_strobe_n(cycle_addr_strobe_n),
        .cycle_addr_strobe_oe(cycle_addr_strobe_oe));
    asm_sys_model i_asm_sys_model (.mclk(mclk), .rdy_go(rdy_go), .hold_go(hold_go),
        .mask_go(mask_go), .ready_n(ready_n), .float_req(float_req),
        .bit20_mask_in_n(bit20_mask_in_n));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Offer a request; returns at the negedge after the taking edge
    task automatic issue(input logic [22:0] a, input logic [1:0] sel);
        req = '{a, sel[1], sel[0], 3'h5};
        req_valid = 1;
        while (req_ready !== 1'h1) @(negedge mclk);
        @(negedge mclk) req_valid = 0;
    endtask
    // One ready pulse, then room for the pin synchronisers
    task automatic rdy();
        @(negedge mclk) rdy_go = 1;
        @(negedge mclk) rdy_go = 0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic t_nonpipe();
        issue(23'h12345, 2'h3);
        chk(bus_out, {23'h12345, 2'h0, 3'h5});
        chk(cycle_addr_strobe_n, 0);
        chk(req_ready, 0);
        @(negedge mclk) chk(cycle_addr_strobe_n, 1);
        chk(req_ready, 0);
        rdy();
        $display("test nonpipe done");
    endtask
    // Second strobe must hold until the earlier cycle gets ready
    task automatic t_pipe();
        pipeline_en = 1;
        issue(23'h00100, 2'h1);
        @(negedge mclk);
        issue(23'h00200, 2'h2);
        repeat (3) @(negedge mclk);
        chk(cycle_addr_strobe_n, 0);
        chk(req_ready, 0);
        rdy();
        chk(cycle_addr_strobe_n, 1);
        rdy();
        pipeline_en = 0;
        $display("test pipe done");
    endtask
    task automatic mstep(input logic en, pg, mg, input logic [22:0] exp);
        @(negedge mclk) {bit20_mask_enable, paging_en, mask_go} = {en, pg, mg};
        repeat (4) @(negedge mclk);
        chk(cache_addr, exp);
    endtask
    task automatic t_mask();
        req = '{23'h7fffff, 1'b0, 1'b0, 3'h5};
        mstep(0, 0, 1, 23'h7fffff);
        mstep(1, 0, 1, 23'h77ffff);
        issue(23'h7fffff, 2'h0);
        chk(bus_out, {23'h77ffff, 2'h0, 3'h5});
        rdy();
        mstep(1, 1, 1, 23'h7fffff);
        issue(23'h7fffff, 2'h0);
        chk(bus_out, {23'h7fffff, 2'h0, 3'h5});
        rdy();
        mstep(1, 0, 0, 23'h7fffff);
        $display("test mask done");
    endtask
    task automatic t_float();
        hold_go = 1;
        repeat (4) @(negedge mclk);
        chk({cycle_addr_strobe_oe, bus_out_oe}, 0);
        chk(req_ready, 0);
        hold_go = 0;
        repeat (4) @(negedge mclk);
        chk({cycle_addr_strobe_oe, bus_out_oe}, 3);
        $display("test float done");
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge mclk);
        srst = 0;
        t_nonpipe();
        t_pipe();
        t_mask();
        t_float();
        print_verdict();
    end
endmodule
